/* File: verilog/vm_regs.svh */
// Register offsets, field positions, reset values and timing counts of the regulator voltage monitor
// ==================================================================
// Summary of operation
// - Separate overvoltage and undervoltage watch for five switchers and two linear regulators.
// - Per-regulator undervoltage code: 00=95%, 01=93%, 10=91%, 11=89% of nominal.
// - Per-regulator overvoltage code: 00=105%, 01=107%, 10=109%, 11=111% of nominal.
// - One shared undervoltage filter code: 5, 15, 25 or 40 us.
// - Shared undervoltage filter code resets to binary 10.
// - One shared overvoltage filter code: 30, 50, 80 or 125 us.
// - Shared overvoltage filter code resets to binary 00.
// - Per-regulator monitor enable bit: 1 watches the regulator, 0 stops watching.
// - All monitor enable bits come up as 1 after reset.
// - With protection on, monitor enable bits change only via the unlock sequence.
// - Detection is blanked after regulator turn-on until it reaches regulation.
// - Turning a monitor off clears its undervoltage and overvoltage flags.
// - Filter timers count ticks of a 100 kHz low-power clock.
`ifndef VM_REGS_SVH
`define VM_REGS_SVH

// ==================================================================
// Register byte offsets
`define VM_ADDR_CTRL 8'h00
`define VM_ADDR_LEVEL 8'h04
`define VM_ADDR_MONEN 8'h08
`define VM_ADDR_KEY 8'h0C
`define VM_ADDR_STATUS 8'h10
`define VM_ADDR_EVENT 8'h14
`define VM_ADDR_MASK 8'h18

// ==================================================================
// Field positions
`define VM_CTRL_UVF_LSB 0
`define VM_CTRL_OVF_LSB 4
`define VM_CTRL_PROT_BIT 8
`define VM_LVL_OV_LSB 16
`define VM_STAT_OV_LSB 8
`define VM_STAT_ACT_LSB 16

// ==================================================================
// Reset values and unlock key
`define VM_UVF_RST 2'h2
`define VM_OVF_RST 2'h0
`define VM_PROT_RST 1'h0
`define VM_MONEN_RST 8'hFF
`define VM_PROT_KEY 32'h0000_00A5

// ==================================================================
// Timing
`define VM_PCLK_KHZ 10000
`define VM_LP_KHZ 100
`define VM_TICK_DIV (`VM_PCLK_KHZ / `VM_LP_KHZ)
`define VM_UV_US0 5
`define VM_UV_US1 15
`define VM_UV_US2 25
`define VM_UV_US3 40
`define VM_OV_US0 30
`define VM_OV_US1 50
`define VM_OV_US2 80
`define VM_OV_US3 125
`define VM_TICKS(us) (((us) * `VM_LP_KHZ + 999) / 1000)

`endif

/* File: verilog/vm_pkg.sv */
// Types and shared decoding of the regulator voltage monitor
`include "vm_regs.svh"
package vm_pkg;
  typedef enum logic {VM_IDLE, VM_RESP} vm_bus_t;
  typedef logic [3:0] vm_ticks_t;

  // Filter code to whole 100 kHz ticks, rounded up
  function automatic vm_ticks_t uv_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: uv_ticks = 4'(`VM_TICKS(`VM_UV_US0));
      2'h1: uv_ticks = 4'(`VM_TICKS(`VM_UV_US1));
      2'h2: uv_ticks = 4'(`VM_TICKS(`VM_UV_US2));
      default: uv_ticks = 4'(`VM_TICKS(`VM_UV_US3));
    endcase
  endfunction

  function automatic vm_ticks_t ov_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: ov_ticks = 4'(`VM_TICKS(`VM_OV_US0));
      2'h1: ov_ticks = 4'(`VM_TICKS(`VM_OV_US1));
      2'h2: ov_ticks = 4'(`VM_TICKS(`VM_OV_US2));
      default: ov_ticks = 4'(`VM_TICKS(`VM_OV_US3));
    endcase
  endfunction
endpackage

/* File: verilog/vm_filt_if.sv */
// Shared tick and filter lengths from the monitor core to its filters
`timescale 1ns/1ns
`default_nettype none
interface vm_filt_if;
  logic tick;
  vm_pkg::vm_ticks_t uv_limit;
  vm_pkg::vm_ticks_t ov_limit;
  modport ctl (output tick, output uv_limit, output ov_limit);
  modport flt (input tick, input uv_limit, input ov_limit);
endinterface
`default_nettype wire

/* File: verilog/vm_sync.sv */
// Three-stage synchroniser, output moves where stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module vm_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } vm_sync_st_t;
  vm_sync_st_t st;
  vm_sync_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q = (st.s2 & st.s3) | (st.q & (st.s2 | st.s3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;
endmodule // vm_sync
`default_nettype wire

/* File: verilog/vm_filter.sv */
// Debounce filter for one comparator bit
`timescale 1ns/1ns
`default_nettype none
module vm_filter #(
  parameter bit IS_OV = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  vm_filt_if.flt fif,
  input wire logic cond,
  output logic flag,
  output logic set_pulse
);
  typedef struct packed {
    vm_pkg::vm_ticks_t count;
    logic flag;
    logic pulse;
  } vm_filt_st_t;
  vm_filt_st_t st;
  vm_filt_st_t next_st;
  vm_pkg::vm_ticks_t limit;

  assign limit = IS_OV ? fif.ov_limit : fif.uv_limit;

  always_comb begin
    next_st = st;
    next_st.pulse = 1'b0;
    if (!cond) begin
      next_st.count = '0;
      next_st.flag = 1'b0;
    end else if (!st.flag && fif.tick) begin
      // First tick is partial, so one extra tick keeps the time a minimum
      if (st.count >= limit) begin
        next_st.flag = 1'b1;
        next_st.pulse = 1'b1;
        next_st.count = '0;
      end else begin
        next_st.count = 4'(st.count + 4'h1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.flag;
  assign set_pulse = st.pulse;
endmodule // vm_filter
`default_nettype wire

/* File: verilog/vm_monitor.sv */
// Regulator voltage monitor core with APB registers and event interrupt
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "vm_regs.svh"
module vm_monitor #(
  parameter int NUM_SW = 5,
  parameter int NUM_LDO = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SW+NUM_LDO-1:0] uv_cmp,
  input wire logic [NUM_SW+NUM_LDO-1:0] ov_cmp,
  input wire logic [NUM_SW+NUM_LDO-1:0] reg_on,
  input wire logic [NUM_SW+NUM_LDO-1:0] reg_in_reg,
  output logic [2*NUM_SW-1:0] switcher_undervolt_level_sel,
  output logic [2*NUM_LDO-1:0] linear_undervolt_level_sel,
  output logic [2*NUM_SW-1:0] switcher_overvolt_level_sel,
  output logic [2*NUM_LDO-1:0] linear_overvolt_level_sel,
  output logic [NUM_SW-1:0] switcher_monitor_on,
  output logic [NUM_LDO-1:0] linear_monitor_on,
  output logic [NUM_SW+NUM_LDO-1:0] comparator_enable,
  output logic [NUM_SW+NUM_LDO-1:0] undervolt_flag,
  output logic [NUM_SW+NUM_LDO-1:0] overvolt_flag,
  output logic irq
);
  localparam int NR = NUM_SW + NUM_LDO;
  localparam int TW = 7;
  localparam logic [TW-1:0] TICK_LAST = TW'(`VM_TICK_DIV - 1);

  // ==================================================================
  // State
  typedef struct packed {
    vm_pkg::vm_bus_t bus;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] uv_filt;
    logic [1:0] ov_filt;
    logic protect;
    logic armed;
    logic [2*NR-1:0] uv_lvl;
    logic [2*NR-1:0] ov_lvl;
    logic [NR-1:0] mon_on;
    logic [NR-1:0] ramp_done;
    logic [NR-1:0] active;
    logic [NR-1:0] ev_uv;
    logic [NR-1:0] ev_ov;
    logic [NR-1:0] mask_uv;
    logic [NR-1:0] mask_ov;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic irq;
  } vm_mon_st_t;

  localparam vm_mon_st_t RST_ST = '{
    bus: vm_pkg::VM_IDLE,
    uv_filt: `VM_UVF_RST,
    ov_filt: `VM_OVF_RST,
    protect: `VM_PROT_RST,
    mon_on: NR'(`VM_MONEN_RST),
    default: '0
  };

  vm_mon_st_t st;
  vm_mon_st_t next_st;

  // ==================================================================
  // Input synchronisers and filters
  logic [NR-1:0] uv_s;
  logic [NR-1:0] ov_s;
  logic [NR-1:0] on_s;
  logic [NR-1:0] inreg_s;
  logic [NR-1:0] uv_set;
  logic [NR-1:0] ov_set;

  vm_sync #(.W(4 * NR)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({reg_in_reg, reg_on, ov_cmp, uv_cmp}),
    .q({inreg_s, on_s, ov_s, uv_s})
  );

  vm_filt_if fif ();
  assign fif.tick = st.tick;
  assign fif.uv_limit = vm_pkg::uv_ticks(st.uv_filt);
  assign fif.ov_limit = vm_pkg::ov_ticks(st.ov_filt);

  // One filter pair per regulator keeps them independent
  for (genvar i = 0; i < NR; i++) begin : g_reg
    vm_filter #(.IS_OV(1'b0)) u_uv (
      .pclk(pclk),
      .presetn(presetn),
      .fif(fif),
      .cond(uv_s[i] & st.active[i]),
      .flag(undervolt_flag[i]),
      .set_pulse(uv_set[i])
    );
    vm_filter #(.IS_OV(1'b1)) u_ov (
      .pclk(pclk),
      .presetn(presetn),
      .fif(fif),
      .cond(ov_s[i] & st.active[i]),
      .flag(overvolt_flag[i]),
      .set_pulse(ov_set[i])
    );
  end

  // ==================================================================
  // Next state
  logic access;
  logic commit;
  logic wr;
  logic mapped;
  logic refused;
  logic [31:0] rdata;
  logic [31:0] stat_word;
  logic [NR-1:0] clr_uv;
  logic [NR-1:0] clr_ov;

  always_comb begin
    next_st = st;
    access = psel && penable && st.bus == vm_pkg::VM_IDLE;
    commit = psel && penable && st.bus == vm_pkg::VM_RESP;
    wr = commit && pwrite && !st.pslverr;
    stat_word = '0;
    stat_word[NR-1:0] = undervolt_flag;
    stat_word[`VM_STAT_OV_LSB +: NR] = overvolt_flag;
    stat_word[`VM_STAT_ACT_LSB +: NR] = st.active;
    rdata = '0;
    mapped = 1'b1;
    case (paddr)
      `VM_ADDR_CTRL: begin
        rdata[`VM_CTRL_UVF_LSB +: 2] = st.uv_filt;
        rdata[`VM_CTRL_OVF_LSB +: 2] = st.ov_filt;
        rdata[`VM_CTRL_PROT_BIT] = st.protect;
      end
      `VM_ADDR_LEVEL: begin
        rdata[2*NR-1:0] = st.uv_lvl;
        rdata[`VM_LVL_OV_LSB +: 2*NR] = st.ov_lvl;
      end
      `VM_ADDR_MONEN: rdata[NR-1:0] = st.mon_on;
      `VM_ADDR_KEY: rdata[0] = st.armed;
      `VM_ADDR_STATUS: rdata = stat_word;
      `VM_ADDR_EVENT: begin
        rdata[NR-1:0] = st.ev_uv;
        rdata[`VM_STAT_OV_LSB +: NR] = st.ev_ov;
      end
      `VM_ADDR_MASK: begin
        rdata[NR-1:0] = st.mask_uv;
        rdata[`VM_STAT_OV_LSB +: NR] = st.mask_ov;
      end
      default: mapped = 1'b0;
    endcase
    // Status is live hardware state, so writes to it are errors
    refused = !mapped
      || (pwrite && paddr == `VM_ADDR_STATUS)
      || (pwrite && paddr == `VM_ADDR_MONEN && st.protect && !st.armed);

    // Bus: one wait state, answer registered so every output is a flop
    next_st.pready = 1'b0;
    case (st.bus)
      vm_pkg::VM_IDLE: begin
        if (access) begin
          next_st.bus = vm_pkg::VM_RESP;
          next_st.pready = 1'b1;
          next_st.pslverr = refused;
          next_st.prdata = (pwrite || refused) ? 32'h0000_0000 : rdata;
        end
      end
      vm_pkg::VM_RESP: begin
        next_st.bus = vm_pkg::VM_IDLE;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0000_0000;
      end
      default: next_st.bus = vm_pkg::VM_IDLE;
    endcase

    // Register writes land at the edge that samples pready
    clr_uv = '0;
    clr_ov = '0;
    if (wr) begin
      next_st.armed = 1'b0;
      case (paddr)
        `VM_ADDR_CTRL: begin
          next_st.uv_filt = pwdata[`VM_CTRL_UVF_LSB +: 2];
          next_st.ov_filt = pwdata[`VM_CTRL_OVF_LSB +: 2];
          next_st.protect = pwdata[`VM_CTRL_PROT_BIT];
        end
        `VM_ADDR_LEVEL: begin
          next_st.uv_lvl = pwdata[2*NR-1:0];
          next_st.ov_lvl = pwdata[`VM_LVL_OV_LSB +: 2*NR];
        end
        `VM_ADDR_MONEN: next_st.mon_on = pwdata[NR-1:0];
        `VM_ADDR_KEY: next_st.armed = (pwdata == `VM_PROT_KEY);
        `VM_ADDR_EVENT: begin
          clr_uv = pwdata[NR-1:0];
          clr_ov = pwdata[`VM_STAT_OV_LSB +: NR];
        end
        `VM_ADDR_MASK: begin
          next_st.mask_uv = pwdata[NR-1:0];
          next_st.mask_ov = pwdata[`VM_STAT_OV_LSB +: NR];
        end
        default: next_st.armed = 1'b0;
      endcase
    end

    // Ramp blanking: held until the regulator reports regulation
    next_st.ramp_done = on_s & (st.ramp_done | inreg_s);
    // Disabling drops active, which clears both filter flags
    next_st.active = st.mon_on & on_s & st.ramp_done;

    // Low-power tick; filters only advance on it
    if (st.tick_cnt == TICK_LAST) begin
      next_st.tick_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = TW'(st.tick_cnt + 1'b1);
      next_st.tick = 1'b0;
    end

    // Sticky events, a new set beats a same-cycle clear
    next_st.ev_uv = (st.ev_uv & ~clr_uv) | uv_set;
    next_st.ev_ov = (st.ev_ov & ~clr_ov) | ov_set;
    next_st.irq = |((next_st.ev_uv & next_st.mask_uv) | (next_st.ev_ov & next_st.mask_ov));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  // ==================================================================
  // Outputs
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign switcher_undervolt_level_sel = st.uv_lvl[2*NUM_SW-1:0];
  assign linear_undervolt_level_sel = st.uv_lvl[2*NR-1:2*NUM_SW];
  assign switcher_overvolt_level_sel = st.ov_lvl[2*NUM_SW-1:0];
  assign linear_overvolt_level_sel = st.ov_lvl[2*NR-1:2*NUM_SW];
  assign switcher_monitor_on = st.mon_on[NUM_SW-1:0];
  assign linear_monitor_on = st.mon_on[NR-1:NUM_SW];
  assign comparator_enable = st.active;
  assign irq = st.irq;
endmodule // vm_monitor
`default_nettype wire

/* File: testbench/vm_chk_monitor.sv */
// Port checker of the voltage monitor, bound to its top module
`timescale 1ns/1ns
`default_nettype none
module vm_chk #(
  parameter int NUM_SW = 5,
  parameter int NUM_LDO = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_SW+NUM_LDO-1:0] uv_cmp,
  input wire logic [NUM_SW+NUM_LDO-1:0] ov_cmp,
  input wire logic [NUM_SW-1:0] switcher_monitor_on,
  input wire logic [NUM_LDO-1:0] linear_monitor_on,
  input wire logic [NUM_SW+NUM_LDO-1:0] comparator_enable,
  input wire logic [NUM_SW+NUM_LDO-1:0] undervolt_flag,
  input wire logic [NUM_SW+NUM_LDO-1:0] overvolt_flag,
  input wire logic irq
);
  // ==================================================================
  // Unbroken comparator time of regulator 0
  logic [8:0] uvc;
  logic [8:0] ovc;
  wire wr_done = pready & pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uvc <= 9'h000;
      ovc <= 9'h000;
    end else begin
      uvc <= (uv_cmp[0] && comparator_enable[0]) ? uvc + 9'(uvc != 9'h1FF) : 9'h000;
      ovc <= (ov_cmp[0] && comparator_enable[0]) ? ovc + 9'(ovc != 9'h1FF) : 9'h000;
    end
  end
  // ==================================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && !pready; endsequence
  a_one_wait: assert property (s_setup ##1 s_access |=> pready)
    else $error("no answer after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_qual: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_flag_clear: assert property (((undervolt_flag | overvolt_flag) & ~comparator_enable & ~$past(comparator_enable)) == '0)
    else $error("flag stands while off");
  a_enable_cause: assert property ((comparator_enable & ~$past({linear_monitor_on, switcher_monitor_on})) == '0)
    else $error("enabled with monitor off");
  a_uv_persist: assert property ($rose(undervolt_flag[0]) |-> uvc >= 9'h032)
    else $error("undervolt flag too early");
  a_ov_persist: assert property ($rose(overvolt_flag[0]) |-> ovc >= 9'h12C)
    else $error("overvolt flag too early");
  a_monen_write: assert property (!$stable({linear_monitor_on, switcher_monitor_on}) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("monitor enable moved alone");
  a_irq_drop: assert property ($fell(irq) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("irq dropped alone");
endmodule // vm_chk
bind vm_monitor vm_chk #(.NUM_SW(NUM_SW), .NUM_LDO(NUM_LDO)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .uv_cmp, .ov_cmp, .switcher_monitor_on, .linear_monitor_on, .comparator_enable,
  .undervolt_flag, .overvolt_flag, .irq);
`default_nettype wire

/* File: testbench/vm_analog.sv */
// Regulators and their window comparators
`timescale 1ns/1ns
`default_nettype none
module vm_analog #(
  parameter int RAMP = 600
) (
  input wire logic pclk,
  input wire logic [6:0] on_cmd,
  input wire logic [6:0] uv_cmd,
  input wire logic [6:0] ov_cmd,
  output logic [6:0] reg_on,
  output logic [6:0] reg_in_reg,
  output logic [6:0] uv_cmp,
  output logic [6:0] ov_cmp
);
  // ==================================================================
  // Soft-start ramp, long enough to trip an unblanked filter
  int cnt [7];
  always_ff @(posedge pclk)
    for (int i = 0; i < 7; i++)
      cnt[i] <= !on_cmd[i] ? 0 : (cnt[i] < RAMP ? cnt[i] + 1 : RAMP);
  always_comb
    for (int i = 0; i < 7; i++)
      reg_in_reg[i] = on_cmd[i] && cnt[i] == RAMP;
  assign reg_on = on_cmd;
  // Output sits below threshold until regulation
  assign uv_cmp = uv_cmd | ~reg_in_reg;
  assign ov_cmp = ov_cmd & reg_on;
endmodule // vm_analog
`default_nettype wire

/* File: testbench/tb_top.sv */
// Register-level tests of the regulator voltage monitor
`timescale 1ns/1ns
`default_nettype none
`include "vm_regs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [6:0] on_cmd = 7'h7F, uv_cmd = 7'h00, ov_cmd = 7'h00, seen = 7'h00;
  logic [6:0] uv_cmp, ov_cmp, reg_on, reg_in_reg, ce, uvf, ovf;
  logic [9:0] swu, swo;
  logic [3:0] ldu, ldo;
  logic [4:0] swm;
  logic [1:0] ldm;
  int err_total = 0, n_checks = 0, n;
  int us_t [8] = '{5, 15, 25, 40, 30, 50, 80, 125};
  vm_monitor dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .uv_cmp, .ov_cmp, .reg_on, .reg_in_reg, .switcher_undervolt_level_sel(swu), .linear_undervolt_level_sel(ldu),
    .switcher_overvolt_level_sel(swo), .linear_overvolt_level_sel(ldo), .switcher_monitor_on(swm),
    .linear_monitor_on(ldm), .comparator_enable(ce), .undervolt_flag(uvf), .overvolt_flag(ovf), .irq);
  vm_analog u_ana (.pclk, .on_cmd, .uv_cmd, .ov_cmd, .reg_on, .reg_in_reg, .uv_cmp, .ov_cmp);
  always #50 pclk = ~pclk;
  // ==================================================================
  // Tasks
  task automatic wrap_up();
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) begin
      @(posedge pclk);
      seen |= uvf;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
    apb(1'b1, a, d);
    `CHK(e, x)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    `CHK(e, xe)
    `CHK(q, x)
  endtask
  task automatic filt(input int k);
    wr(`VM_ADDR_CTRL, {26'h0, k[1:0], 2'h0, k[1:0]}, 1'b0);
    if (k < 4) uv_cmd[0] <= 1'b1;
    else ov_cmd[0] <= 1'b1;
    n = 0;
    do begin
      step(1);
      n++;
    end while (((k < 4) ? uvf[0] : ovf[0]) !== 1'b1 && n < 3000);
    `CHK(n >= us_t[k] * 10, 1'b1)
    `CHK(n <= ((us_t[k] + 9) / 10 + 2) * 100, 1'b1)
    uv_cmd[0] <= 1'b0;
    ov_cmd[0] <= 1'b0;
    step(10);
    `CHK(uvf[0] | ovf[0], 1'b0)
  endtask
  // ==================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    `CHK({ldm, swm, uvf, ovf}, {7'h7F, 14'h0000})
    presetn <= 1'b1;
    rd(`VM_ADDR_CTRL, 32'h2, 1'b0);
    rd(`VM_ADDR_MONEN, 32'h7F, 1'b0);
    rd(`VM_ADDR_LEVEL, 32'h0, 1'b0);
    for (int c = 0; c < 4; c++) begin
      wr(`VM_ADDR_LEVEL, {2'h0, {7{~c[1:0]}}, 2'h0, {7{c[1:0]}}}, 1'b0);
      step(2);
      `CHK({swu, ldu}, {7{c[1:0]}})
      `CHK({swo, ldo}, {7{~c[1:0]}})
    end
    step(700);
    `CHK(ce, 7'h7F)
    rd(`VM_ADDR_STATUS, 32'h007F_0000, 1'b0);
    for (int k = 0; k < 8; k++) filt(k);
    rd(`VM_ADDR_EVENT, 32'h0000_0101, 1'b0);
    `CHK(irq, 1'b0)
    wr(`VM_ADDR_MASK, 32'h1, 1'b0);
    step(3);
    `CHK(irq, 1'b1)
    wr(`VM_ADDR_EVENT, 32'h1, 1'b0);
    step(3);
    `CHK(irq, 1'b0)
    rd(`VM_ADDR_EVENT, 32'h0000_0100, 1'b0);
    // Ramp blanking on regulator 1
    wr(`VM_ADDR_CTRL, 32'h0, 1'b0);
    on_cmd[1] <= 1'b0;
    step(20);
    on_cmd[1] <= 1'b1;
    seen = 7'h00;
    step(300);
    `CHK(ce[1], 1'b0)
    step(350);
    `CHK({seen[1], ce[1]}, 2'b01)
    // Monitor off clears the undervoltage flag
    uv_cmd[2] <= 1'b1;
    step(400);
    `CHK(uvf[2], 1'b1)
    wr(`VM_ADDR_MONEN, 32'h7B, 1'b0);
    step(8);
    `CHK({uvf[2], ce[2], swm}, {2'b00, 5'h1B})
    uv_cmd[2] <= 1'b0;
    // Protected writes
    wr(`VM_ADDR_CTRL, 32'h100, 1'b0);
    wr(`VM_ADDR_MONEN, 32'h7F, 1'b1);
    rd(`VM_ADDR_MONEN, 32'h7B, 1'b0);
    wr(`VM_ADDR_KEY, `VM_PROT_KEY, 1'b0);
    wr(`VM_ADDR_MONEN, 32'h7F, 1'b0);
    wr(`VM_ADDR_KEY, `VM_PROT_KEY, 1'b0);
    wr(`VM_ADDR_CTRL, 32'h100, 1'b0);
    wr(`VM_ADDR_MONEN, 32'h7B, 1'b1);
    rd(`VM_ADDR_MONEN, 32'h7F, 1'b0);
    // Broken condition restarts the filter
    wr(`VM_ADDR_CTRL, 32'h0, 1'b0);
    seen = 7'h00;
    repeat (6) begin
      uv_cmd[3] <= 1'b1;
      step(40);
      uv_cmd[3] <= 1'b0;
      step(20);
    end
    `CHK(seen[3], 1'b0)
    rd(8'h1C, 32'h0, 1'b1);
    wr(`VM_ADDR_STATUS, 32'h0, 1'b1);
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
